/* File: core/uaci_top.sv */
// per-channel uart interrupt logic with its register port
`timescale 1ns/10ps
`default_nettype none
module uaci_top #(
   parameter int LW = 7  // fifo level width
) (
   // clock and reset
   input  wire logic          mclk_i,
   input  wire logic          reset_i,
   // register port
   input  wire logic [3:0]    addr_i,
   input  wire logic [7:0]    wdata_i,
   input  wire logic          wr_i,
   input  wire logic          rd_i,
   output var  logic [7:0]    rdata_o,
   // receive datapath status
   input  wire logic [7:0]    rx_data_i,        // head of rx fifo
   input  wire logic          rx_char_loaded_i, // char entered fifo/rhr
   input  wire logic [LW-1:0] rx_level_i,
   input  wire logic [LW-1:0] rx_trigger_i,
   input  wire logic [3:0]    rx_err_i,         // overrun,parity,frame,break
   input  wire logic          rx_fifo_err_i,
   input  wire logic          bit_tick_i,
   input  wire logic [3:0]    char_bits_i,
   // transmit datapath status
   input  wire logic          thr_empty_i,
   input  wire logic          tx_below_trig_i,
   input  wire logic          tsr_empty_i,      // tx fifo and shifter empty
   input  wire logic          auto_rs485_i,
   // modem and flow
   input  wire logic [7:0]    modem_status_i,
   input  wire logic          xon_det_i,
   input  wire logic          xoff_det_i,
   input  wire logic          special_det_i,
   input  wire logic          rts_state_i,      // from own receiver logic
   input  wire logic          cts_pin_i,        // asynchronous pin
   // side effects and status
   output var  logic          rhr_read_o,
   output var  logic          thr_write_o,
   output var  logic          msr_read_o,
   output var  logic          fifo_en_o,
   output var  logic          polled_mode_o,
   output var  logic          irq_o
);
   import uaci_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [7:0]  mask_q;      // interrupt_mask
   logic [7:0]  efr_q;       // enhanced_function_register
   logic        fen_q;       // fifo enable
   logic        lsr_q;       // sticky line status event
   logic        tout_q;      // receive timeout pending
   logic        tx_q;        // transmit ready pending
   logic        txc_q;       // previous transmit condition
   logic        sw_q;        // xon/xoff seen
   logic        spc_q;       // special char seen
   logic        rts_q;       // rts change pending
   logic        cts_q;       // cts change pending
   logic        rtsp_q;      // previous rts level
   logic        ctsp_q;      // previous cts level
   logic [7:0]  rdata_q;
   logic        rhr_rd_q;
   logic        thr_wr_q;
   logic        msr_rd_q;
   logic        irq_q;
   logic        pol_q;

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   wire rd_rhr_w  = rd_i && addr_i == OFS_RHR_THR;
   wire wr_thr_w  = wr_i && addr_i == OFS_RHR_THR;
   wire wr_mask_w = wr_i && addr_i == OFS_MASK;
   wire rd_isr_w  = rd_i && addr_i == OFS_ISR_FCR;
   wire wr_fcr_w  = wr_i && addr_i == OFS_ISR_FCR;
   wire rd_lsr_w  = rd_i && addr_i == OFS_LSR;
   wire rd_msr_w  = rd_i && addr_i == OFS_MSR;
   wire wr_efr_w  = wr_i && addr_i == OFS_EFR;

   // ----------------------------------------------------------------
   // event sources
   // ----------------------------------------------------------------
   logic cts_lvl_w;   // filtered cts pin
   logic tout_exp_w;  // timer pulse

   wire data_rdy_w = rx_level_i != '0;
   wire rx_lvl_w   = fen_q ? (rx_level_i >= rx_trigger_i)
                           : data_rdy_w;
   wire ls_set_w   = rx_char_loaded_i && (rx_err_i != 4'h0);
   // half-duplex mode waits for the whole transmitter to drain
   wire tx_cond_w  = auto_rs485_i ? tsr_empty_i
                                  : (fen_q ? tx_below_trig_i : thr_empty_i);
   wire tx_set_w   = tx_cond_w && !txc_q;
   wire sw_set_w   = xon_det_i || xoff_det_i;
   // auto flow counts only a low-to-high edge, otherwise any edge
   wire rts_set_w  = efr_q[EFR_ARTS] ? (rts_state_i && !rtsp_q)
                                     : (rts_state_i != rtsp_q);
   wire cts_set_w  = efr_q[EFR_ACTS] ? (cts_lvl_w && !ctsp_q)
                                     : (cts_lvl_w != ctsp_q);
   wire [7:0] lsr_w = {rx_fifo_err_i, tsr_empty_i, thr_empty_i,
                       rx_err_i, data_rdy_w};

   // ----------------------------------------------------------------
   // gated pending terms
   // ----------------------------------------------------------------
   wire p_ls_w = mask_q[MASK_LS] && lsr_q;
   wire p_rx_w = mask_q[MASK_RX] && rx_lvl_w;
   wire p_to_w = mask_q[MASK_RX] && tout_q;
   wire p_tx_w = mask_q[MASK_TX] && tx_q;
   wire p_ms_w = mask_q[MASK_MS] && (modem_status_i[3:0] != 4'h0);
   wire p_sw_w = mask_q[MASK_SW] && (sw_q || spc_q);
   wire p_fl_w = (mask_q[MASK_RTS] && rts_q) || (mask_q[MASK_CTS] && cts_q);
   wire any_w  = p_ls_w || p_rx_w || p_to_w || p_tx_w
                 || p_ms_w || p_sw_w || p_fl_w;

   // ----------------------------------------------------------------
   // priority encode: only the top source is reported
   // ----------------------------------------------------------------
   logic [5:0] src_w;
   always_comb begin
      if (p_ls_w) begin
         src_w = SRC_LS;
      end else if (p_rx_w) begin
         src_w = SRC_RX;
      end else if (p_to_w) begin
         src_w = SRC_TO;
      end else if (p_tx_w) begin
         src_w = SRC_TX;
      end else if (p_ms_w) begin
         src_w = SRC_MS;
      end else if (p_sw_w) begin
         src_w = SRC_SW;
      end else if (p_fl_w) begin
         src_w = SRC_FL;
      end else begin
         src_w = SRC_NONE;
      end
   end

   // isr read acknowledges the reported source only when it is tx ready or xon/xoff/special
   wire ack_tx_w = rd_isr_w && src_w == SRC_TX;
   wire ack_sw_w = rd_isr_w && src_w == SRC_SW;
   wire [7:0] isr_w = {{2{fen_q}}, src_w};

   // ----------------------------------------------------------------
   // read mux, unmapped reads return zero
   // ----------------------------------------------------------------
   logic [7:0] rmux_w;
   always_comb begin
      if (addr_i == OFS_RHR_THR) begin
         rmux_w = rx_data_i;
      end else if (addr_i == OFS_MASK) begin
         rmux_w = mask_q;
      end else if (addr_i == OFS_ISR_FCR) begin
         rmux_w = isr_w;
      end else if (addr_i == OFS_LSR) begin
         rmux_w = lsr_w;
      end else if (addr_i == OFS_MSR) begin
         rmux_w = modem_status_i;
      end else if (addr_i == OFS_EFR) begin
         rmux_w = efr_q;
      end else begin
         rmux_w = 8'h00;
      end
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   uaci_sync3 u_cts_sync (
      .mclk_i  (mclk_i),
      .reset_i (reset_i),
      .pin_i   (cts_pin_i),
      .level_o (cts_lvl_w)
   );

   uaci_rx_timer u_tout (
      .mclk_i      (mclk_i),
      .reset_i     (reset_i),
      .bit_tick_i  (bit_tick_i),
      .char_bits_i (char_bits_i),
      .restart_i   (rx_char_loaded_i || rd_rhr_w),
      .active_i    (fen_q && data_rdy_w),
      .expire_o    (tout_exp_w)
   );

   // ----------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         mask_q <= MASK_RST;
         efr_q  <= EFR_RST;
         fen_q  <= FEN_RST;
      end else begin
         if (wr_mask_w) begin
            // upper enables stay frozen unless enhanced bit is set
            mask_q <= (wdata_i & MASK_WMASK)
                      | ((efr_q[EFR_ENH] ? wdata_i : mask_q) & MASK_EMASK);
         end
         if (wr_efr_w) begin
            efr_q <= wdata_i;
         end
         if (wr_fcr_w) begin
            fen_q <= wdata_i[FCR_FEN];
         end
      end
   end

   // ----------------------------------------------------------------
   // sticky flags; a set in the clearing cycle wins
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         lsr_q  <= 1'b0;
         tout_q <= 1'b0;
         tx_q   <= 1'b0;
         txc_q  <= 1'b0;
         sw_q   <= 1'b0;
         spc_q  <= 1'b0;
         rts_q  <= 1'b0;
         cts_q  <= 1'b0;
         rtsp_q <= 1'b0;
         ctsp_q <= 1'b0;
      end else begin
         txc_q  <= tx_cond_w;
         rtsp_q <= rts_state_i;
         ctsp_q <= cts_lvl_w;
         lsr_q  <= ls_set_w || (lsr_q && !rd_lsr_w);
         tout_q <= tout_exp_w || (tout_q && !rd_rhr_w);
         tx_q   <= tx_set_w || (tx_q && !ack_tx_w && !wr_thr_w);
         sw_q   <= sw_set_w || (sw_q && !ack_sw_w);
         // next ordinary char also retires a special-char event
         spc_q  <= special_det_i
                   || (spc_q && !ack_sw_w && !rx_char_loaded_i);
         rts_q  <= rts_set_w || (rts_q && !rd_msr_w);
         cts_q  <= cts_set_w || (cts_q && !rd_msr_w);
      end
   end

   // ----------------------------------------------------------------
   // registered outputs
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         rdata_q  <= 8'h00;
         rhr_rd_q <= 1'b0;
         thr_wr_q <= 1'b0;
         msr_rd_q <= 1'b0;
         irq_q    <= 1'b0;
         pol_q    <= 1'b0;
      end else begin
         rdata_q  <= rd_i ? rmux_w : 8'h00;
         rhr_rd_q <= rd_rhr_w;
         thr_wr_q <= wr_thr_w;
         msr_rd_q <= rd_msr_w;   // datapath clears its delta bits
         irq_q    <= any_w;
         pol_q    <= fen_q && mask_q[3:0] == 4'h0;
      end
   end

   assign rdata_o       = rdata_q;
   assign rhr_read_o    = rhr_rd_q;
   assign thr_write_o   = thr_wr_q;
   assign msr_read_o    = msr_rd_q;
   assign fifo_en_o     = fen_q;
   assign polled_mode_o = pol_q;
   assign irq_o         = irq_q;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   sequence s_tx_report;
      ack_tx_w && !tx_set_w && !wr_thr_w;
   endsequence
   sequence s_tx_gone;
      !tx_q ##1 (!tx_q || $past(tx_set_w));
   endsequence

   property p_ls_set;
      @(posedge mclk_i) disable iff (reset_i)
      ls_set_w |=> lsr_q;
   endproperty
   a_ls_set: assert property (p_ls_set)
      else $error("line status event not latched");

   property p_ls_clr;
      @(posedge mclk_i) disable iff (reset_i)
      rd_lsr_w && !ls_set_w |=> !lsr_q;
   endproperty
   a_ls_clr: assert property (p_ls_clr)
      else $error("line status flag survived lsr read");

   property p_tx_isr_clr;
      @(posedge mclk_i) disable iff (reset_i)
      s_tx_report |=> s_tx_gone;
   endproperty
   a_tx_isr_clr: assert property (p_tx_isr_clr)
      else $error("tx ready not cleared by isr read");

   property p_tout_clr;
      @(posedge mclk_i) disable iff (reset_i)
      rd_rhr_w && !tout_exp_w |=> !tout_q;
   endproperty
   a_tout_clr: assert property (p_tout_clr)
      else $error("timeout survived rhr read");

   property p_mask_lock;
      @(posedge mclk_i) disable iff (reset_i)
      wr_mask_w && !efr_q[EFR_ENH] |=> mask_q[7:5] == $past(mask_q[7:5]);
   endproperty
   a_mask_lock: assert property (p_mask_lock)
      else $error("locked mask bits changed");

   property p_irq;
      @(posedge mclk_i) disable iff (reset_i)
      any_w |=> irq_o && (src_w != SRC_NONE || $past(any_w));
   endproperty
   a_irq: assert property (p_irq)
      else $error("irq missing while pending");

   property p_isr_fifo;
      @(posedge mclk_i) disable iff (reset_i)
      rd_isr_w |=> rdata_o[7:6] == {2{$past(fen_q)}};
   endproperty
   a_isr_fifo: assert property (p_isr_fifo)
      else $error("isr fifo bits wrong");

   property p_isr_ls;
      @(posedge mclk_i) disable iff (reset_i)
      rd_isr_w && p_ls_w |=> rdata_o[5:0] == SRC_LS;
   endproperty
   a_isr_ls: assert property (p_isr_ls)
      else $error("line status not reported first");

   property p_isr_none;
      @(posedge mclk_i) disable iff (reset_i)
      rd_isr_w && !any_w |=> rdata_o[0] && !irq_o;
   endproperty
   a_isr_none: assert property (p_isr_none)
      else $error("idle isr bit 0 not set");

   property p_sw_set;
      @(posedge mclk_i) disable iff (reset_i)
      sw_set_w && mask_q[MASK_SW] && !wr_mask_w |=> p_sw_w ##1 irq_o;
   endproperty
   a_sw_set: assert property (p_sw_set)
      else $error("xon/xoff interrupt not raised");
endmodule
`default_nettype wire

/* File: core/uaci_pkg.sv */
// constants shared by the uart channel interrupt logic
// Function
// - rx data interrupt at char or trigger
// - fifo rx interrupt drops below trigger
// - data ready on load, clear when empty
// - fifos on, mask 3:0 clear: polled
// - line status bits report rx/tx state
// - tx ready interrupt, rs485 uses tx empty
// - line status interrupt on rx errors
// - modem interrupt on any delta bit
// - mask 7:5 locked unless enhanced bit
// - interrupt on rts or cts transition
// - auto flow: rising pin raises flow
// - timeout after four chars twelve bits
// - xon xoff special char raise interrupt
// - lsr read, msr read clear interrupts
// - rhr read clears receive timeout
// - isr read or thr write clears tx
// - isr read clears xon xoff special
// - source codes for priorities one to four
// - source codes for five to seven, none
// - isr reports highest pending source only
// - isr bit 0 low while pending
// - isr bits 7:6 show fifo enable
// - fcr bit 0 enables fifos, default 0
package uaci_pkg;
   // -----------------------------------------------------------------
   // register offsets on the channel port
   // -----------------------------------------------------------------
   localparam logic [3:0] OFS_RHR_THR = 4'h0;  // rx read / tx write
   localparam logic [3:0] OFS_MASK    = 4'h1;  // interrupt_mask
   localparam logic [3:0] OFS_ISR_FCR = 4'h2;  // source read / fifo ctl write
   localparam logic [3:0] OFS_LSR     = 4'h5;  // line status
   localparam logic [3:0] OFS_MSR     = 4'h6;  // modem status
   localparam logic [3:0] OFS_EFR     = 4'h9;  // enhanced function
   // -----------------------------------------------------------------
   // field positions and reset values
   // -----------------------------------------------------------------
   localparam int         MASK_RX    = 0;      // rx data / timeout
   localparam int         MASK_TX    = 1;      // tx ready
   localparam int         MASK_LS    = 2;      // line status
   localparam int         MASK_MS    = 3;      // modem status
   localparam int         MASK_SW    = 5;      // xon/xoff/special
   localparam int         MASK_RTS   = 6;      // rts transition
   localparam int         MASK_CTS   = 7;      // cts transition
   localparam int         EFR_ENH    = 4;      // unlocks mask 7:5
   localparam int         EFR_ARTS   = 6;      // auto rts flow
   localparam int         EFR_ACTS   = 7;      // auto cts flow
   localparam int         FCR_FEN    = 0;      // fifo enable
   localparam logic [7:0] MASK_WMASK = 8'h0f;  // always-writable mask bits
   localparam logic [7:0] MASK_EMASK = 8'he0;  // bits needing enhanced bit
   localparam logic [7:0] MASK_RST   = 8'h00;
   localparam logic [7:0] EFR_RST    = 8'h00;
   localparam logic       FEN_RST    = 1'b0;
   // -----------------------------------------------------------------
   // interrupt source codes, bits 5:0
   // -----------------------------------------------------------------
   localparam logic [5:0] SRC_LS   = 6'h06;
   localparam logic [5:0] SRC_RX   = 6'h04;
   localparam logic [5:0] SRC_TO   = 6'h0c;
   localparam logic [5:0] SRC_TX   = 6'h02;
   localparam logic [5:0] SRC_MS   = 6'h00;
   localparam logic [5:0] SRC_SW   = 6'h10;
   localparam logic [5:0] SRC_FL   = 6'h20;
   localparam logic [5:0] SRC_NONE = 6'h01;
   // -----------------------------------------------------------------
   // receive timeout: chars and extra bit times
   // -----------------------------------------------------------------
   localparam int         TOUT_CHARS = 4;
   localparam int         TOUT_BITS  = 12;
endpackage

/* File: core/uaci_sync3.sv */
// three-stage synchroniser with agreement filter for one pin
`timescale 1ns/10ps
`default_nettype none
module uaci_sync3 (
   // clock and reset
   input  wire logic mclk_i,
   input  wire logic reset_i,
   // pin and clean level
   input  wire logic pin_i,
   output var  logic level_o
);
   logic s1_q;   // metastable stage, read only by s2
   logic s2_q;
   logic s3_q;
   logic lvl_q;  // filtered level

   // ----------------------------------------------------------------
   // shift chain; level moves only when stages two and three agree
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         s1_q  <= 1'b0;
         s2_q  <= 1'b0;
         s3_q  <= 1'b0;
         lvl_q <= 1'b0;
      end else begin
         s1_q <= pin_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            lvl_q <= s3_q;  // glitch shorter than a cycle is ignored
         end
      end
   end

   assign level_o = lvl_q;
endmodule
`default_nettype wire

/* File: core/uaci_rx_timer.sv */
// receive timeout timer counting bit-time ticks
`timescale 1ns/10ps
`default_nettype none
module uaci_rx_timer #(
   parameter int CW = 7  // counter width, holds 4*12+12
) (
   // clock and reset
   input  wire logic         mclk_i,
   input  wire logic         reset_i,
   // timing inputs
   input  wire logic         bit_tick_i,   // one pulse per bit time
   input  wire logic [3:0]   char_bits_i,  // bits in one frame
   input  wire logic         restart_i,    // char loaded or rhr read
   input  wire logic         active_i,     // rx data waiting
   // expiry
   output var  logic         expire_o      // one-cycle pulse
);
   import uaci_pkg::*;

   logic [CW-1:0] cnt_q;    // elapsed bit times
   logic          done_q;   // fired since last restart
   logic          exp_q;
   logic [CW-1:0] limit_w;  // four chars plus twelve bits

   assign limit_w = CW'(TOUT_CHARS * char_bits_i + TOUT_BITS);

   // ----------------------------------------------------------------
   // count while data waits; fire once, then hold until restart
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         cnt_q  <= '0;
         done_q <= 1'b0;
         exp_q  <= 1'b0;
      end else begin
         exp_q <= 1'b0;
         if (restart_i || !active_i) begin
            cnt_q  <= '0;
            done_q <= 1'b0;
         end else if (bit_tick_i && !done_q) begin
            if (cnt_q + 1'b1 >= limit_w) begin
               exp_q  <= 1'b1;
               done_q <= 1'b1;
            end
            cnt_q <= cnt_q + 1'b1;
         end
      end
   end

   assign expire_o = exp_q;
endmodule
`default_nettype wire

/* File: tb/uaci_host.sv */
// host bus master model driving the channel register port
`timescale 1ns/10ps
`default_nettype none
module uaci_host (
   // clock
   input  wire logic       mclk_i,
   // register port toward the channel
   output var  logic [3:0] addr_o,
   output var  logic [7:0] wdata_o,
   output var  logic       wr_o,
   output var  logic       rd_o,
   input  wire logic [7:0] rdata_i
);
   // bus idles with both strobes low
   initial begin
      addr_o = 4'h0;
      wdata_o = 8'h00;
      wr_o = 1'b0;
      rd_o = 1'b0;
   end
   // one-cycle write strobe, slave never stalls
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      addr_o  <= a;
      wdata_o <= d;
      wr_o    <= 1'b1;
      @(posedge mclk_i);
      wr_o    <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe, so take it there
   task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
      @(posedge mclk_i);
      addr_o <= a;
      rd_o   <= 1'b1;
      @(posedge mclk_i);
      rd_o   <= 1'b0;
      #1 d = rdata_i;
   endtask
endmodule
`default_nettype wire

/* File: tb/uart_channel_interrupt_logic_bench.sv */
// self-checking bench for the uart channel interrupt logic
`timescale 1ns/10ps
`default_nettype none
module uart_channel_interrupt_logic_bench;
   import uaci_pkg::*;
   // ----------------------------------------------------------
   // stimulus, observation and model state
   // ----------------------------------------------------------
   logic       mclk_i = 1'b0;
   logic       reset_i = 1'b1;
   logic [3:0] addr, err = 4'h0;
   logic [7:0] wdata, rdata, modem_status_register = 8'h00;
   logic       wr, rd, fen_seen, pol_seen, irq, ld = 1'b0;
   logic [6:0] lvl = 7'h00, trig = 7'h04;
   logic       ferr = 1'b0, thre = 1'b0, tsre = 1'b0, txb = 1'b0, tk = 1'b0;
   logic       xon = 1'b0, xoff = 1'b0, spec = 1'b0, rts = 1'b0, cts = 1'b0;
   int         err_count = 0, cmp_count = 0, seed = 32'hba87;
   int         pend = 0;             // pending sources, bit 0 is top priority
   logic [7:0] fen_bits = 8'h00;     // expected isr bits 7:6
   logic [5:0] codes [7] = '{SRC_LS, SRC_RX, SRC_TO, SRC_TX, SRC_MS, SRC_SW, SRC_FL};
   always #10 mclk_i = ~mclk_i;
   uaci_host host (.mclk_i(mclk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
      .rdata_i(rdata));
   // frame size tied to eight bits, bit tick driven by the bench
   uaci_top dut (.mclk_i(mclk_i), .reset_i(reset_i), .addr_i(addr), .wdata_i(wdata),
      .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .rx_data_i(8'h5a), .rx_char_loaded_i(ld),
      .rx_level_i(lvl), .rx_trigger_i(trig), .rx_err_i(err), .rx_fifo_err_i(ferr),
      .bit_tick_i(tk), .char_bits_i(4'h8), .thr_empty_i(thre), .tx_below_trig_i(txb),
      .tsr_empty_i(tsre), .auto_rs485_i(1'b0), .modem_status_i(modem_status_register), .xon_det_i(xon),
      .xoff_det_i(xoff), .special_det_i(spec), .rts_state_i(rts), .cts_pin_i(cts),
      .rhr_read_o(), .thr_write_o(), .msr_read_o(), .fifo_en_o(fen_seen),
      .polled_mode_o(pol_seen), .irq_o(irq));
   // highest pending source wins, none pending reads code 01
   function automatic logic [7:0] exp_isr();
      for (int i = 0; i < 7; i++)
         if (pend[i]) return fen_bits | {2'b00, codes[i]};
      return fen_bits | {2'b00, SRC_NONE};
   endfunction
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic rchk(input string what, input logic [3:0] a, input logic [7:0] exp);
      logic [7:0] d;
      host.rd_reg(a, d);
      check(what, d, exp);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge mclk_i);
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // watchdog: whole run needs well under a thousand cycles
   initial begin
      #(20 * 5000);
      err_count++;
      summarize();
   end
   initial begin
      tick(4);
      reset_i <= 1'b0;
      rchk("isr", OFS_ISR_FCR, exp_isr());
      rchk("mask", OFS_MASK, 8'h00);
      check("irq", {7'h00, irq}, 8'h00);
      // upper mask bits stay locked until the enhanced bit is set
      host.wr_reg(OFS_MASK, 8'hff);
      rchk("mask", OFS_MASK, 8'h0f);
      host.wr_reg(OFS_EFR, 8'h10);
      host.wr_reg(OFS_ISR_FCR, 8'h01);
      fen_bits = 8'hc0;
      host.wr_reg(OFS_MASK, 8'he0);
      tick(2);
      check("polled", {7'h00, pol_seen}, 8'h01);
      check("fifo_en", {7'h00, fen_seen}, 8'h01);
      rchk("isr", OFS_ISR_FCR, exp_isr());
      host.wr_reg(OFS_MASK, 8'hff);
      rchk("mask", OFS_MASK, 8'hef);
      $display("test mask and fifo done");
      // xon, xoff and special char each raise and clear on an isr read
      for (int k = 0; k < 3; k++) begin
         @(posedge mclk_i);
         {xon, xoff, spec} <= 3'b100 >> k;
         @(posedge mclk_i);
         {xon, xoff, spec} <= 3'b000;
         pend[5] = 1;
         tick(3);
         check("irq", {7'h00, irq}, 8'h01);
         rchk("isr", OFS_ISR_FCR, exp_isr());
         pend[5] = 0;
         rchk("isr", OFS_ISR_FCR, exp_isr());
      end
      $display("test soft flow done");
      // line status, rx data, tx ready and modem all pending at once
      @(posedge mclk_i);
      err <= 4'($random(seed)) | 4'h1;
      lvl <= trig + 7'($random(seed) & 3);
      {ferr, thre, tsre} <= 3'($random(seed));
      modem_status_register <= 8'($random(seed)) | 8'h01;
      txb <= 1'b1;
      ld <= 1'b1;
      @(posedge mclk_i);
      ld <= 1'b0;
      pend = 'h1b;
      tick(4);
      rchk("isr", OFS_ISR_FCR, exp_isr());
      rchk("lsr", OFS_LSR, {ferr, tsre, thre, err, 1'b1});
      pend[0] = 0;
      @(posedge mclk_i);
      err <= 4'h0;
      tick(2);
      rchk("isr", OFS_ISR_FCR, exp_isr());
      @(posedge mclk_i);
      lvl <= trig - 7'h01;
      pend[1] = 0;
      tick(2);
      rchk("isr", OFS_ISR_FCR, exp_isr());
      pend[3] = 0;
      rchk("isr", OFS_ISR_FCR, exp_isr());
      rchk("msr", OFS_MSR, modem_status_register);
      @(posedge mclk_i);
      modem_status_register <= modem_status_register & 8'hf0;
      pend[4] = 0;
      tick(2);
      rchk("isr", OFS_ISR_FCR, exp_isr());
      $display("test priority done");
      // rts and cts transitions, cleared by a modem status read
      @(posedge mclk_i);
      rts <= 1'b1;
      cts <= 1'b1;
      pend[6] = 1;
      tick(8);
      rchk("isr", OFS_ISR_FCR, exp_isr());
      rchk("msr", OFS_MSR, modem_status_register);
      pend[6] = 0;
      rchk("isr", OFS_ISR_FCR, exp_isr());
      // rx timeout: data below trigger waits four frames plus twelve bit times
      @(posedge mclk_i);
      tk <= 1'b1;
      tick(TOUT_CHARS * 8 + TOUT_BITS);
      check("irq", {7'h00, irq}, 8'h00);
      tick(3);
      check("irq", {7'h00, irq}, 8'h01);
      tk <= 1'b0;
      pend[2] = 1;
      rchk("isr", OFS_ISR_FCR, exp_isr());
      rchk("rhr", OFS_RHR_THR, 8'h5a);
      pend[2] = 0;
      rchk("isr", OFS_ISR_FCR, exp_isr());
      // tx ready again, this time cleared by a holding register write
      @(posedge mclk_i);
      txb <= 1'b0;
      lvl <= 7'h00;
      tick(2);
      txb <= 1'b1;
      tick(3);
      check("irq", {7'h00, irq}, 8'h01);
      host.wr_reg(OFS_RHR_THR, 8'($random(seed)));
      tick(3);
      check("irq", {7'h00, irq}, 8'h00);
      rchk("unmapped", 4'hf, 8'h00);
      check("polled", {7'h00, pol_seen}, 8'h00);
      host.wr_reg(OFS_ISR_FCR, 8'h00);
      fen_bits = 8'h00;
      rchk("isr", OFS_ISR_FCR, exp_isr());
      $display("test flow and tx done");
      summarize();
   end
endmodule
`default_nettype wire
